// ---- logic/sdl_status_flags.sv ----
// Purpose: sticky status flag groups, reported per status type code
// Assumes: event inputs from core_clk logic; modem pins asynchronous
// Notes: a report read clears that group; a same-cycle event survives
`timescale 1ns/1ps
module sdl_status_flags
    import sdl_status_pkg::*;
#(
    parameter int unsigned WRITE_FAIL_LIMIT = WRITE_FAIL_CYCLES,
    parameter int COUNT_W = 16
)
(
    input wire logic core_clk,
    input wire logic rst,
    input sdl_events_t events,
    input wire logic [COUNT_W-1:0] buffer_count_word,
    input wire logic tx_mode,
    input wire logic char_sent,
    input wire logic dsr_pin,
    input wire logic dsr_required,
    input wire logic rlsd_pin,
    input wire logic carrier_watch,
    input wire logic host_rd_req,
    input wire logic [7:0] host_type_code,
    output logic host_rd_ack,
    output sdl_report_t report,
    output logic [GROUPS-1:0] status_pending
);

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic [3:0] type_to_group(input logic [7:0] code);
        logic [3:0] r;
        r = 4'h0;
        if (code == TYPE_XFER)
            r = {1'b1, G_XFER};
        else if (code == TYPE_EXC)
            r = {1'b1, G_EXC};
        else if (code == TYPE_REC)
            r = {1'b1, G_REC};
        else if (code == TYPE_FUNC)
            r = {1'b1, G_FUNC};
        else if (code == TYPE_UNR)
            r = {1'b1, G_UNR};
        return r;
    endfunction

    function automatic logic [7:0] used_mask(input int g);
        return USED_MASK[g];
    endfunction

    // ****************************************
    // modem pin synchronisers
    // ****************************************
    logic [2:0] dsr_sync_reg;
    logic [2:0] dsr_sync_next;
    logic [2:0] rlsd_sync_reg;
    logic [2:0] rlsd_sync_next;
    logic dsr_drop;
    logic carrier_loss;

    always_comb
    begin
        dsr_sync_next = {dsr_sync_reg[1:0], dsr_pin};
        rlsd_sync_next = {rlsd_sync_reg[1:0], rlsd_pin};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dsr_sync_reg <= 3'h0;
            rlsd_sync_reg <= 3'h0;
        end
        else
        begin
            dsr_sync_reg <= dsr_sync_next;
            rlsd_sync_reg <= rlsd_sync_next;
        end
    end

    assign dsr_drop = dsr_sync_reg[2] && !dsr_sync_reg[1] && dsr_required;
    assign carrier_loss = rlsd_sync_reg[2] && !rlsd_sync_reg[1] && carrier_watch;

    // ****************************************
    // buffer count zero detect and watchdog
    // ****************************************
    logic [COUNT_W-1:0] count_prev_reg;
    logic [COUNT_W-1:0] count_prev_next;
    logic count_zero;
    logic wr_fail;
    always_comb
    begin
        count_prev_next = buffer_count_word;
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            count_prev_reg <= '0;
        else
            count_prev_reg <= count_prev_next;
    end
    assign count_zero = (buffer_count_word == '0) && (count_prev_reg != '0);

    sdl_tx_watchdog #(
        .LIMIT(WRITE_FAIL_LIMIT)
    ) u_watchdog (
        .core_clk(core_clk),
        .rst(rst),
        .tx_mode(tx_mode),
        .char_sent(char_sent),
        .timeout_pulse(wr_fail)
    );

    // ****************************************
    // event to flag set vectors
    // ****************************************
    logic [7:0] set_raw [GROUPS];
    logic [7:0] set_full [GROUPS];

    always_comb
    begin
        for (int g = 0; g < GROUPS; g++)
            set_raw[g] = 8'h00;
        set_raw[G_XFER][B_WR_CONF] = events.wr_msg_confirmed;
        set_raw[G_XFER][B_WR_LIST] = events.wr_list_complete;
        set_raw[G_XFER][B_COUNT_ZERO] = count_zero;
        set_raw[G_XFER][B_RD_AVAIL] = events.rd_msg_ok;
        set_raw[G_XFER][B_EMPTY_I] = events.empty_iframe;
        set_raw[G_XFER][B_RD_TRUNC] = events.rd_truncated;
        set_raw[G_EXC][7:1] = events.ext_set;
        set_raw[G_REC][B_RX_LOCK] = events.rx_lockout;
        set_raw[G_REC][B_ALT_OVR] = events.alt_buf_overrun;
        set_raw[G_REC][B_CTL_OVR] = events.ctl_buf_overrun;
        set_raw[G_REC][B_TX_UNDR] = events.tx_underrun;
        set_raw[G_FUNC][B_FN_DONE] = events.func_done;
        set_raw[G_FUNC][B_QUIESCE] = events.quiesced;
        set_raw[G_FUNC][B_CARRIER] = carrier_loss;
        set_raw[G_FUNC][B_LOOPWIRE] = events.loop_wire_err;
        set_raw[G_FUNC][B_BAD_FUNC] = events.bad_func_code;
        set_raw[G_UNR][B_DSR_ERR] = dsr_drop;
        set_raw[G_UNR][B_MCHK] = events.machine_check;
        set_raw[G_UNR][B_WR_FAIL] = wr_fail;
        set_raw[G_UNR][B_HW_BAD] = events.hw_status_bad;
        for (int g = 0; g < GROUPS; g++)
        begin
            set_full[g] = set_raw[g] & used_mask(g);
            if ((set_raw[g] & ILK_MASK[g]) != 8'h00)
                set_full[g][B_ILK] = 1'b1;
        end
    end

    // ****************************************
    // read handshake state
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANS = 2'b10
    } sdl_rd_state_t;

    sdl_rd_state_t state_reg;
    sdl_rd_state_t state_next;
    logic [3:0] rd_grp;
    logic rd_take;

    assign rd_grp = type_to_group(host_type_code);
    assign rd_take = (state_reg == ST_IDLE) && host_rd_req;

    // ****************************************
    // sticky flags and report
    // ****************************************
    logic [7:0] flags_reg [GROUPS];
    logic [7:0] flags_next [GROUPS];
    logic [7:0] ext_reg;
    logic [7:0] ext_next;
    sdl_report_t report_reg;
    sdl_report_t report_next;

    always_comb
    begin
        state_next = state_reg;
        report_next = report_reg;
        ext_next = ext_reg;
        for (int g = 0; g < GROUPS; g++)
            flags_next[g] = flags_reg[g];
        case (state_reg)
            ST_IDLE:
            begin
                if (host_rd_req)
                begin
                    state_next = ST_ANS;
                    report_next.type_code = host_type_code;
                    report_next.flags = 8'h00;
                    report_next.ext = 8'h00;
                    if (rd_grp[3])
                    begin
                        report_next.flags = flags_reg[rd_grp[2:0]];
                        flags_next[rd_grp[2:0]] = 8'h00;
                        if (rd_grp[2:0] == G_EXC)
                        begin
                            report_next.ext = ext_reg;
                            ext_next = 8'h00;
                        end
                    end
                end
            end
            ST_ANS:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        // set wins over the read clear
        for (int g = 0; g < GROUPS; g++)
            flags_next[g] = flags_next[g] | set_full[g];
        if (events.ext_set != 7'h00)
            ext_next = ext_next | events.ext_detail;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            ext_reg <= 8'h00;
            report_reg <= '0;
            for (int g = 0; g < GROUPS; g++)
                flags_reg[g] <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            ext_reg <= ext_next;
            report_reg <= report_next;
            for (int g = 0; g < GROUPS; g++)
                flags_reg[g] <= flags_next[g];
        end
    end

    assign host_rd_ack = (state_reg == ST_ANS);
    assign report = report_reg;

    generate
        for (genvar gi = 0; gi < GROUPS; gi++)
        begin : g_pend
            assign status_pending[gi] = (flags_reg[gi] != 8'h00);
            a_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
                (flags_reg[gi] & ~used_mask(gi)) == 8'h00)
                else $error("unused flag bit set");
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    sequence s_read_taken;
        (state_reg == ST_IDLE) && host_rd_req;
    endsequence

    sequence s_answer;
        host_rd_ack ##1 !host_rd_ack;
    endsequence

    a_read_answer: assert property (@(posedge core_clk) disable iff (rst)
        s_read_taken |=> s_answer)
        else $error("read not answered in one cycle");
    a_xfer_report: assert property (@(posedge core_clk) disable iff (rst)
        (s_read_taken and (host_type_code == TYPE_XFER))
        |=> report.flags == $past(flags_reg[G_XFER]))
        else $error("type 01 report wrong");
    a_bad_type_zero: assert property (@(posedge core_clk) disable iff (rst)
        (s_read_taken and !rd_grp[3]) |=> report.flags == 8'h00)
        else $error("undefined type reported flags");
    a_wr_confirm: assert property (@(posedge core_clk) disable iff (rst)
        events.wr_msg_confirmed |=> flags_reg[G_XFER][B_WR_CONF] && flags_reg[G_XFER][B_ILK])
        else $error("write confirm flag missing");
    a_list_done: assert property (@(posedge core_clk) disable iff (rst)
        events.wr_list_complete |=> flags_reg[G_XFER][B_WR_LIST])
        else $error("write list flag missing");
    a_count_zero: assert property (@(posedge core_clk) disable iff (rst)
        ($past(buffer_count_word) != '0 && buffer_count_word == '0)
        |=> flags_reg[G_XFER][B_COUNT_ZERO])
        else $error("count zero flag missing");
    a_rd_avail: assert property (@(posedge core_clk) disable iff (rst)
        events.rd_msg_ok |=> flags_reg[G_XFER][B_RD_AVAIL])
        else $error("read available flag missing");
    a_empty_iframe: assert property (@(posedge core_clk) disable iff (rst)
        events.empty_iframe |=> flags_reg[G_XFER][B_EMPTY_I])
        else $error("empty frame flag missing");
    a_truncated: assert property (@(posedge core_clk) disable iff (rst)
        events.rd_truncated |=> flags_reg[G_XFER][B_RD_TRUNC])
        else $error("truncated flag missing");
    a_ilk_rec_none: assert property (@(posedge core_clk) disable iff (rst)
        (events.rx_lockout && !events.tx_underrun && !flags_reg[G_REC][B_ILK]
         && !rd_take) |=> !flags_reg[G_REC][B_ILK])
        else $error("interlock set by plain flag");
    a_ext_valid: assert property (@(posedge core_clk) disable iff (rst)
        (events.ext_set != 7'h00) |=> ((flags_reg[G_EXC][7:1] & $past(events.ext_set))
        == $past(events.ext_set)) && flags_reg[G_EXC][B_ILK])
        else $error("extension flag missing");
    a_underrun_ilk: assert property (@(posedge core_clk) disable iff (rst)
        events.tx_underrun |=> flags_reg[G_REC][B_TX_UNDR] && flags_reg[G_REC][B_ILK])
        else $error("underrun flag missing");
    a_func_done: assert property (@(posedge core_clk) disable iff (rst)
        events.func_done |=> flags_reg[G_FUNC][B_FN_DONE] && flags_reg[G_FUNC][B_ILK])
        else $error("function done flag missing");
    a_dsr_error: assert property (@(posedge core_clk) disable iff (rst)
        (dsr_required && $fell(dsr_sync_reg[1])) |=> flags_reg[G_UNR][B_DSR_ERR])
        else $error("modem ready drop not flagged");
    a_unr_no_ilk: assert property (@(posedge core_clk) disable iff (rst)
        !flags_reg[G_UNR][B_ILK])
        else $error("unrecoverable group shows interlock");

endmodule // sdl_status_flags

// ---- logic/sdl_status_pkg.sv ----
// Purpose: shared constants and carriers for the link status flag block
// Assumes: 100 MHz core clock
// Notes: flag bit positions per status type, group indices, timing
package sdl_status_pkg;

    // ****************************************
    // status type codes and groups
    // ****************************************
    localparam logic [7:0] TYPE_XFER = 8'h01;
    localparam logic [7:0] TYPE_EXC = 8'h02;
    localparam logic [7:0] TYPE_REC = 8'h04;
    localparam logic [7:0] TYPE_FUNC = 8'h08;
    localparam logic [7:0] TYPE_UNR = 8'h0C;
    localparam int GROUPS = 5;
    localparam logic [2:0] G_XFER = 3'h0;
    localparam logic [2:0] G_EXC = 3'h1;
    localparam logic [2:0] G_REC = 3'h2;
    localparam logic [2:0] G_FUNC = 3'h3;
    localparam logic [2:0] G_UNR = 3'h4;
    // interlocked bits and defined bits per group
    localparam logic [7:0] ILK_MASK [GROUPS] = '{8'hF6, 8'hFE, 8'h20, 8'h02, 8'h00};
    localparam logic [7:0] USED_MASK [GROUPS] = '{8'hF7, 8'hFF, 8'h2F, 8'hF3, 8'hE4};

    // ****************************************
    // flag bit positions
    // ****************************************
    localparam int B_ILK = 0;
    localparam int B_WR_CONF = 1;
    localparam int B_WR_LIST = 2;
    localparam int B_COUNT_ZERO = 4;
    localparam int B_RD_AVAIL = 5;
    localparam int B_EMPTY_I = 6;
    localparam int B_RD_TRUNC = 7;
    localparam int B_RX_LOCK = 1;
    localparam int B_ALT_OVR = 2;
    localparam int B_CTL_OVR = 3;
    localparam int B_TX_UNDR = 5;
    localparam int B_FN_DONE = 1;
    localparam int B_QUIESCE = 4;
    localparam int B_CARRIER = 5;
    localparam int B_LOOPWIRE = 6;
    localparam int B_BAD_FUNC = 7;
    localparam int B_DSR_ERR = 2;
    localparam int B_MCHK = 5;
    localparam int B_WR_FAIL = 6;
    localparam int B_HW_BAD = 7;

    // ****************************************
    // timing
    // ****************************************
    localparam longint unsigned CLK_PERIOD_NS = 64'd10;
    localparam longint unsigned WRITE_FAIL_TIME_MS = 64'd8200;
    localparam int unsigned WRITE_FAIL_CYCLES =
        32'(WRITE_FAIL_TIME_MS * 64'd1000000 / CLK_PERIOD_NS);

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic wr_msg_confirmed;
        logic wr_list_complete;
        logic rd_msg_ok;
        logic empty_iframe;
        logic rd_truncated;
        logic rx_lockout;
        logic alt_buf_overrun;
        logic ctl_buf_overrun;
        logic tx_underrun;
        logic func_done;
        logic quiesced;
        logic loop_wire_err;
        logic bad_func_code;
        logic machine_check;
        logic hw_status_bad;
        logic [7:1] ext_set;
        logic [7:0] ext_detail;
    } sdl_events_t;

    typedef struct packed {
        logic [7:0] type_code;
        logic [7:0] flags;
        logic [7:0] ext;
    } sdl_report_t;

endpackage

// ---- logic/sdl_tx_watchdog.sv ----
// Purpose: transmit watchdog, no character sent within the limit
// Assumes: tx_mode and char_sent from logic on core_clk
// Notes: one pulse per silent interval
`timescale 1ns/1ps
module sdl_tx_watchdog
    import sdl_status_pkg::*;
#(
    parameter int unsigned LIMIT = WRITE_FAIL_CYCLES,
    parameter int CW = $clog2(LIMIT + 1)
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tx_mode,
    input wire logic char_sent,
    output logic timeout_pulse
);

    // ****************************************
    // silence counter
    // ****************************************
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic fire_reg;
    logic fire_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        fire_next = 1'b0;
        if (!tx_mode || char_sent)
        begin
            cnt_next = '0;
        end
        else if (cnt_reg != CW'(LIMIT))
        begin
            cnt_next = cnt_reg + CW'(1);
            fire_next = (cnt_next == CW'(LIMIT));
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg <= '0;
            fire_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            fire_reg <= fire_next;
        end
    end

    assign timeout_pulse = fire_reg;

    a_wd_fires: assert property (@(posedge core_clk) disable iff (rst)
        (tx_mode && !char_sent && cnt_reg == CW'(LIMIT - 1)) |=> timeout_pulse)
        else $error("watchdog did not fire at limit");
    a_wd_needs_tx: assert property (@(posedge core_clk) disable iff (rst)
        timeout_pulse |-> $past(tx_mode) && !$past(char_sent))
        else $error("watchdog fired outside silent transmit");

endmodule // sdl_tx_watchdog

// ---- testbench/sdl_modem_model.sv ----
// Purpose: line side modem model, ready and carrier pins
// Assumes: pins follow the commands after a short skew
// Notes: pins are asynchronous to core_clk
`timescale 1ns/1ps
module sdl_modem_model
(
    input wire logic dsr_on,
    input wire logic carrier_on,
    output wire logic dsr_pin,
    output wire logic rlsd_pin
);
    // skew keeps pin changes off the clock edge
    assign #3 dsr_pin = dsr_on;
    assign #7 rlsd_pin = carrier_on;
endmodule // sdl_modem_model

// ---- testbench/sdl_status_flags_test.sv ----
// Purpose: self-checking bench for the status flag block
// Assumes: short watchdog limit of 20 cycles
// Notes: all inputs but the modem pins change just after the rising edge
`timescale 1ns/1ps
module sdl_status_flags_test
    import sdl_status_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    sdl_events_t ev = '0;
    sdl_events_t e;
    logic [15:0] count_word = 16'h0000;
    logic tx_mode = 1'b0;
    logic char_sent = 1'b0;
    logic dsr_on = 1'b1;
    logic carrier_on = 1'b1;
    logic dsr_pin;
    logic rlsd_pin;
    logic dsr_required = 1'b0;
    logic carrier_watch = 1'b0;
    logic host_rd_req = 1'b0;
    logic [7:0] host_type_code = 8'h00;
    logic host_rd_ack;
    sdl_report_t report;
    logic [4:0] status_pending;
    int error_cnt = 0;
    int checks = 0;
    logic [7:0] tt [15] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h04, 8'h04,
        8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h0C};
    logic [7:0] ff [15] = '{8'h03, 8'h05, 8'h21, 8'h41, 8'h81, 8'h02, 8'h04, 8'h08,
        8'h21, 8'h03, 8'h10, 8'h40, 8'h80, 8'h20, 8'h80};
    logic [4:0] pp [15] = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h04, 5'h04, 5'h04,
        5'h04, 5'h08, 5'h08, 5'h08, 5'h08, 5'h10, 5'h10};

    always #5 core_clk = ~core_clk;

    sdl_status_flags #(.WRITE_FAIL_LIMIT(20)) dut_u
    (
        .core_clk(core_clk), .rst(rst), .events(ev), .buffer_count_word(count_word),
        .tx_mode(tx_mode), .char_sent(char_sent), .dsr_pin(dsr_pin),
        .dsr_required(dsr_required), .rlsd_pin(rlsd_pin),
        .carrier_watch(carrier_watch), .host_rd_req(host_rd_req),
        .host_type_code(host_type_code), .host_rd_ack(host_rd_ack),
        .report(report), .status_pending(status_pending)
    );

    sdl_modem_model modem_u
    (
        .dsr_on(dsr_on), .carrier_on(carrier_on), .dsr_pin(dsr_pin), .rlsd_pin(rlsd_pin)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && checks > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic pulse(input sdl_events_t v);
        ev <= v;
        @(posedge core_clk);
        ev <= '0;
    endtask

    // one host read, report compared as type, flags, extension
    task automatic rd(input logic [7:0] t, input logic [7:0] f, input logic [7:0] x);
        int n;
        n = 0;
        host_rd_req <= 1'b1;
        host_type_code <= t;
        @(posedge core_clk);
        host_rd_req <= 1'b0;
        ev <= '0;
        @(negedge core_clk);
        while (host_rd_ack !== 1'b1 && n < 4)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("ack", {23'h0, host_rd_ack}, 24'h1);
        chk("report", report, {t, f, x});
        @(negedge core_clk);
        chk("ack_len", {23'h0, host_rd_ack}, 24'h0);
        @(posedge core_clk);
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        idle(10);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (tt[i])
        begin
            rd(tt[i], 8'h00, 8'h00);
        end
        foreach (tt[i])
        begin
            pulse(sdl_events_t'(30'h1 << (29 - i)));
            @(negedge core_clk);
            chk("pending", {19'h0, status_pending}, {19'h0, pp[i]});
            @(posedge core_clk);
            rd(tt[i], ff[i], 8'h00);
            rd(tt[i], 8'h00, 8'h00);
        end
        e = '0;
        e.ext_set = 7'h01;
        e.ext_detail = 8'h11;
        pulse(e);
        @(posedge core_clk);
        e.ext_set = 7'h40;
        e.ext_detail = 8'h80;
        pulse(e);
        rd(8'h02, 8'h83, 8'h91);
        rd(8'h02, 8'h00, 8'h00);
        count_word <= 16'h0003;
        idle(2);
        count_word <= 16'h0000;
        idle(2);
        rd(8'h01, 8'h11, 8'h00);
        pulse(sdl_events_t'(30'h1 << 20));
        rd(8'h03, 8'h00, 8'h00);
        ev <= sdl_events_t'(30'h1 << 20);
        rd(8'h08, 8'h03, 8'h00);
        rd(8'h08, 8'h03, 8'h00);
        rd(8'h08, 8'h00, 8'h00);
        dsr_required <= 1'b1;
        carrier_watch <= 1'b1;
        idle(2);
        dsr_on <= 1'b0;
        carrier_on <= 1'b0;
        idle(8);
        rd(8'h0C, 8'h04, 8'h00);
        rd(8'h08, 8'h20, 8'h00);
        tx_mode <= 1'b1;
        idle(15);
        rd(8'h0C, 8'h00, 8'h00);
        char_sent <= 1'b1;
        @(posedge core_clk);
        char_sent <= 1'b0;
        idle(15);
        rd(8'h0C, 8'h00, 8'h00);
        idle(10);
        rd(8'h0C, 8'h40, 8'h00);
        idle(25);
        rd(8'h0C, 8'h00, 8'h00);
        tx_mode <= 1'b0;
        test_done();
    end

    // hang guard
    initial
    begin
        #60000;
        error_cnt++;
        test_done();
    end
endmodule // sdl_status_flags_test
